// ===== gpio_ports_checker.sv
/* Assertions on the ports of the port 6/7/8/12 block.
   Assumes one clock, sys_clk, and the synchronous reset srst. */
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_checker (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Bus and controls
    input wire gpio_ports_pkg::bus_req_type busReq,
    input wire gpio_ports_pkg::bus_rsp_type busRsp_q,
    input wire logic opamp_two_enable,
    input wire gpio_ports_pkg::osc_mode_type oscillator_mode_select,
    // Pin controls
    input wire logic [1:0] sixOut_q,
    input wire logic [1:0] sixOe_q,
    input wire logic [5:0] sevenOe_q,
    input wire logic [5:0] sevenPullup_q,
    input wire logic [3:0] eightOe_q,
    input wire logic [4:0] twelveOe_q,
    input wire logic [4:0] twelveOscOwned_q,
    input wire logic [7:0] dirPortOne_q,
    input wire logic [7:0] dirPortTwo_q
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    sequence sixAllInput;
        busReq.byteWrite && busReq.addr == gpio_ports_pkg::ADDR_DIR_SIX
            && busReq.wdata[1:0] == 2'h3;
    endsequence
    sequence mainHeld;
        oscillator_mode_select.mainOsc [*2];
    endsequence

    a_reset_state: assert property (disable iff (1'b0) $past(srst) |->
        dirPortOne_q == 8'hFF && sixOe_q == 2'h0 && sevenOe_q == 6'h00
        && eightOe_q == 4'h0 && twelveOe_q == 5'h00 && busRsp_q == '0)
        else $error("state after reset wrong");
    a_six_release: assert property (sixAllInput |-> ##2 sixOe_q == 2'h0)
        else $error("port six driven after input setting");
    a_six_no_high: assert property (sixOut_q == 2'h0)
        else $error("port six drives high");
    a_rsp_idle: assert property (!busReq.read |=> busRsp_q == '0)
        else $error("answer without read");
    a_unmapped_read: assert property (busReq.read && busReq.addr[15:8] != 8'hFF
        |=> busRsp_q.hit == 1'b0 && busRsp_q.rdata == 8'h00)
        else $error("unmapped read answered");
    a_dir_byte: assert property (busReq.byteWrite
        && busReq.addr == gpio_ports_pkg::ADDR_DIR_ONE |=> dirPortOne_q == $past(busReq.wdata))
        else $error("byte write to direction lost");
    a_dir_bit: assert property (busReq.bitWrite && !busReq.byteWrite
        && busReq.addr == gpio_ports_pkg::ADDR_DIR_TWO
        |=> dirPortTwo_q[$past(busReq.bitSel)] == $past(busReq.bitValue))
        else $error("bit write to direction lost");
    a_pullup_input: assert property ((sevenPullup_q & sevenOe_q) == 6'h00)
        else $error("pull-up on a driven pin");
    a_opamp_blocks: assert property (opamp_two_enable [*2] |-> eightOe_q[2:0] == 3'h0)
        else $error("digital drive with amplifier on");
    a_osc_idle: assert property ((oscillator_mode_select == '0) [*2]
        |-> twelveOscOwned_q == 5'h00)
        else $error("oscillator holds pins in port mode");
    a_osc_main: assert property (mainHeld |-> twelveOscOwned_q[2:1] == 2'h3)
        else $error("main oscillator pins not taken");
endmodule : gpio_ports_checker

bind gpio_ports_six_to_twelve gpio_ports_checker chk (
    .sys_clk(sys_clk), .srst(srst), .busReq(busReq), .busRsp_q(busRsp_q),
    .opamp_two_enable(opamp_two_enable), .oscillator_mode_select(oscillator_mode_select),
    .sixOut_q(sixOut_q), .sixOe_q(sixOe_q), .sevenOe_q(sevenOe_q),
    .sevenPullup_q(sevenPullup_q), .eightOe_q(eightOe_q), .twelveOe_q(twelveOe_q),
    .twelveOscOwned_q(twelveOscOwned_q), .dirPortOne_q(dirPortOne_q),
    .dirPortTwo_q(dirPortTwo_q)
);
`default_nettype wire

// ===== gpio_ports_pkg.sv
/*
 * Package for the port 6/7/8/12 block: internal bus addresses, reset
 * values, field positions and the carrier structs for the internal bus.
 * Assumes one byte-wide internal bus with bit and byte write strobes.
 */
package gpio_ports_pkg;

    // Internal bus addresses.
    localparam logic [15:0] ADDR_DATA_SIX = 16'hFF06;
    localparam logic [15:0] ADDR_DATA_SEVEN = 16'hFF07;
    localparam logic [15:0] ADDR_DATA_EIGHT = 16'hFF08;
    localparam logic [15:0] ADDR_DATA_TWELVE = 16'hFF0C;
    localparam logic [15:0] ADDR_DIR_ONE = 16'hFF21;
    localparam logic [15:0] ADDR_DIR_TWO = 16'hFF22;
    localparam logic [15:0] ADDR_DIR_THREE = 16'hFF23;
    localparam logic [15:0] ADDR_DIR_SIX = 16'hFF26;
    localparam logic [15:0] ADDR_DIR_SEVEN = 16'hFF27;
    localparam logic [15:0] ADDR_DIR_EIGHT = 16'hFF28;
    localparam logic [15:0] ADDR_DIR_TWELVE = 16'hFF2C;
    localparam logic [15:0] ADDR_ANALOG_CFG = 16'hFF2F;
    localparam logic [15:0] ADDR_PULLUP_SEVEN = 16'hFF37;
    localparam logic [15:0] ADDR_PULLUP_TWELVE = 16'hFF3C;

    // Values after reset.
    localparam logic [7:0] DIR_RESET = 8'hFF;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] PULLUP_RESET = 8'h00;
    localparam logic [4:0] ANALOG_CFG_RESET = 5'h10;
    localparam logic [4:0] ANALOG_CFG_ALL_DIGITAL = 5'h10;

    // Analog configuration codes below which port-eight pins turn analog.
    localparam logic [4:0] ANALOG_CFG_P80_DIGITAL = 5'h09;
    localparam logic [4:0] ANALOG_CFG_P81_DIGITAL = 5'h0A;
    localparam logic [4:0] ANALOG_CFG_P82_DIGITAL = 5'h0B;
    localparam logic [4:0] ANALOG_CFG_P83_DIGITAL = 5'h0F;

    // Implemented pin counts.
    localparam int SIX_PINS = 2;
    localparam int SEVEN_PINS = 6;
    localparam int EIGHT_PINS = 4;
    localparam int TWELVE_PINS = 5;

    // Field positions.
    localparam int OPAMP_OUT_BIT = 1;
    localparam int TWELVE_PULLUP_BIT = 0;
    localparam int OSC_MAIN_LO = 1;
    localparam int OSC_SUB_LO = 3;

    // Oscillator mode select register fields, as seen by the ports.
    localparam logic [7:0] OSC_MODE_RESET = 8'h00;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0] wdata;
        logic byteWrite;
        logic bitWrite;
        logic [2:0] bitSel;
        logic bitValue;
        logic read;
    } bus_req_type;

    typedef struct packed {
        logic [7:0] rdata;
        logic hit;
    } bus_rsp_type;

    typedef struct packed {
        logic mainOsc;
        logic extClk;
        logic subOsc;
    } osc_mode_type;

endpackage : gpio_ports_pkg

// ===== gpio_ports_six_to_twelve.sv
/*
 * Port 6, 7, 8 and 12 logic with the direction registers of ports 1, 2, 3.
 * Assumes the processor drives one bus request per cycle on sys_clk and
 * samples the read answer one cycle later; pad cells resolve pin levels.
 */
`timescale 1ns/1ps
`default_nettype none

module gpio_ports_six_to_twelve (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // Internal bus
    input wire gpio_ports_pkg::bus_req_type busReq,
    output gpio_ports_pkg::bus_rsp_type busRsp_q,
    // Alternate-function controls from other units
    input wire logic opamp_two_enable,
    input wire logic [3:0] converter_channel_select,
    input wire gpio_ports_pkg::osc_mode_type oscillator_mode_select,
    // Port six pins, open drain
    input wire logic [1:0] sixIn,
    output logic [1:0] sixOut_q,
    output logic [1:0] sixOe_q,
    // Port seven pins, also key return inputs
    input wire logic [5:0] sevenIn,
    output logic [5:0] sevenOut_q,
    output logic [5:0] sevenOe_q,
    output logic [5:0] sevenPullup_q,
    output logic [5:0] key_return_input_q,
    // Port eight pins
    input wire logic [3:0] eightIn,
    output logic [3:0] eightOut_q,
    output logic [3:0] eightOe_q,
    output logic [3:0] eightAnalog_q,
    output logic [3:0] eightConvert_q,
    output logic opampOutOnPin_q,
    // Port twelve pins
    input wire logic [4:0] twelveIn,
    output logic [4:0] twelveOut_q,
    output logic [4:0] twelveOe_q,
    output logic intrLvdPullup_q,
    output logic [4:0] twelveOscOwned_q,
    // Direction settings for ports one to three
    output logic [7:0] dirPortOne_q,
    output logic [7:0] dirPortTwo_q,
    output logic [7:0] dirPortThree_q
);

    logic [7:0] dirSix_q;
    logic [7:0] dirSeven_q;
    logic [7:0] dirEight_q;
    logic [7:0] dirTwelve_q;
    logic [7:0] latchSix_q;
    logic [7:0] latchSeven_q;
    logic [7:0] latchEight_q;
    logic [7:0] latchTwelve_q;
    logic [7:0] pullupSeven_q;
    logic [7:0] pullupTwelve_q;
    logic [4:0] analogCfg_q;
    logic [3:0] eightAnalogNow;
    logic [4:0] oscOwned;
    logic [7:0] rdata;
    logic hit;
    logic [7:0] bitMask;
    logic [7:0] analogCfgNext;

    // Three-stage synchronisers; stages two and three must agree.
    logic [16:0] pinRaw;
    logic [16:0] sync1_q;
    logic [16:0] sync2_q;
    logic [16:0] sync3_q;
    logic [16:0] pinLevel_q;

    assign pinRaw = {twelveIn, eightIn, sevenIn, sixIn};

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            sync1_q <= pinRaw;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 17; g++) begin : g_filter
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    pinLevel_q[g] <= 1'b0;
                end else if (sync2_q[g] == sync3_q[g]) begin
                    pinLevel_q[g] <= sync3_q[g];
                end
            end
        end
    endgenerate

    always_comb begin
        bitMask = 8'h00;
        bitMask[busReq.bitSel] = 1'b1;
    end

    function automatic logic [7:0] wr_byte(input logic [7:0] old, input logic [7:0] bm,
                                           input gpio_ports_pkg::bus_req_type r);
        logic [7:0] res;
        res = old;
        if (r.byteWrite) begin
            res = r.wdata;
        end else if (r.bitWrite) begin
            res = r.bitValue ? (old | bm) : (old & ~bm);
        end
        return res;
    endfunction : wr_byte

    function automatic logic sel(input gpio_ports_pkg::bus_req_type r, input logic [15:0] a);
        return (r.byteWrite || r.bitWrite) && (r.addr == a);
    endfunction : sel

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            dirPortOne_q <= gpio_ports_pkg::DIR_RESET;
            dirPortTwo_q <= gpio_ports_pkg::DIR_RESET;
            dirPortThree_q <= gpio_ports_pkg::DIR_RESET;
            dirSix_q <= gpio_ports_pkg::DIR_RESET;
            dirSeven_q <= gpio_ports_pkg::DIR_RESET;
            dirEight_q <= gpio_ports_pkg::DIR_RESET;
            dirTwelve_q <= gpio_ports_pkg::DIR_RESET;
        end else begin
            if (sel(busReq, gpio_ports_pkg::ADDR_DIR_SIX)) begin
                dirSix_q <= wr_byte(dirSix_q, bitMask, busReq);
            end
            if (sel(busReq, gpio_ports_pkg::ADDR_DIR_ONE)) begin
                dirPortOne_q <= wr_byte(dirPortOne_q, bitMask, busReq);
            end
            if (sel(busReq, gpio_ports_pkg::ADDR_DIR_TWO)) begin
                dirPortTwo_q <= wr_byte(dirPortTwo_q, bitMask, busReq);
            end
            if (sel(busReq, gpio_ports_pkg::ADDR_DIR_THREE)) begin
                dirPortThree_q <= wr_byte(dirPortThree_q, bitMask, busReq);
            end
            if (sel(busReq, gpio_ports_pkg::ADDR_DIR_SEVEN)) begin
                dirSeven_q <= wr_byte(dirSeven_q, bitMask, busReq);
            end
            if (sel(busReq, gpio_ports_pkg::ADDR_DIR_EIGHT)) begin
                dirEight_q <= wr_byte(dirEight_q, bitMask, busReq);
            end
            if (sel(busReq, gpio_ports_pkg::ADDR_DIR_TWELVE)) begin
                dirTwelve_q <= wr_byte(dirTwelve_q, bitMask, busReq);
            end
        end
    end

    // The analog configuration is five bits wide, so the byte merge is done on a padded copy.
    assign analogCfgNext = wr_byte({3'h0, analogCfg_q}, bitMask, busReq);

    // Output latches, pull-up selections and analog configuration.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            latchSix_q <= gpio_ports_pkg::LATCH_RESET;
            latchSeven_q <= gpio_ports_pkg::LATCH_RESET;
            latchEight_q <= gpio_ports_pkg::LATCH_RESET;
            latchTwelve_q <= gpio_ports_pkg::LATCH_RESET;
            pullupSeven_q <= gpio_ports_pkg::PULLUP_RESET;
            pullupTwelve_q <= gpio_ports_pkg::PULLUP_RESET;
            analogCfg_q <= gpio_ports_pkg::ANALOG_CFG_RESET;
        end else begin
            if (sel(busReq, gpio_ports_pkg::ADDR_DATA_SIX)) begin
                latchSix_q <= wr_byte(latchSix_q, bitMask, busReq);
            end
            if (sel(busReq, gpio_ports_pkg::ADDR_DATA_SEVEN)) begin
                latchSeven_q <= wr_byte(latchSeven_q, bitMask, busReq);
            end
            if (sel(busReq, gpio_ports_pkg::ADDR_DATA_EIGHT)) begin
                latchEight_q <= wr_byte(latchEight_q, bitMask, busReq);
            end
            if (sel(busReq, gpio_ports_pkg::ADDR_DATA_TWELVE)) begin
                latchTwelve_q <= wr_byte(latchTwelve_q, bitMask, busReq);
            end
            if (sel(busReq, gpio_ports_pkg::ADDR_PULLUP_SEVEN)) begin
                pullupSeven_q <= wr_byte(pullupSeven_q, bitMask, busReq);
            end
            if (sel(busReq, gpio_ports_pkg::ADDR_PULLUP_TWELVE)) begin
                pullupTwelve_q <= wr_byte(pullupTwelve_q, bitMask, busReq);
            end
            if (sel(busReq, gpio_ports_pkg::ADDR_ANALOG_CFG)) begin
                analogCfg_q <= analogCfgNext[4:0];
            end
        end
    end

    // analog only below each pin's threshold
    always_comb begin
        eightAnalogNow[0] = analogCfg_q < gpio_ports_pkg::ANALOG_CFG_P80_DIGITAL;
        eightAnalogNow[1] = analogCfg_q < gpio_ports_pkg::ANALOG_CFG_P81_DIGITAL;
        eightAnalogNow[2] = analogCfg_q < gpio_ports_pkg::ANALOG_CFG_P82_DIGITAL;
        eightAnalogNow[3] = analogCfg_q < gpio_ports_pkg::ANALOG_CFG_P83_DIGITAL;
    end

    always_comb begin
        oscOwned = 5'h00;
        oscOwned[gpio_ports_pkg::OSC_MAIN_LO] = oscillator_mode_select.mainOsc
            || oscillator_mode_select.extClk;
        oscOwned[gpio_ports_pkg::OSC_MAIN_LO + 1] = oscillator_mode_select.mainOsc;
        oscOwned[gpio_ports_pkg::OSC_SUB_LO] = oscillator_mode_select.subOsc;
        oscOwned[gpio_ports_pkg::OSC_SUB_LO + 1] = oscillator_mode_select.subOsc;
    end

    // Pin drive; all outputs registered.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sixOut_q <= 2'h0;
            sixOe_q <= 2'h0;
            sevenOut_q <= 6'h00;
            sevenOe_q <= 6'h00;
            sevenPullup_q <= 6'h00;
            eightOut_q <= 4'h0;
            eightOe_q <= 4'h0;
            eightAnalog_q <= 4'h0;
            eightConvert_q <= 4'h0;
            opampOutOnPin_q <= 1'b0;
            twelveOut_q <= 5'h00;
            twelveOe_q <= 5'h00;
            intrLvdPullup_q <= 1'b0;
            twelveOscOwned_q <= 5'h00;
        end else begin
            sixOut_q <= 2'h0;
            sixOe_q <= ~dirSix_q[1:0] & ~latchSix_q[1:0];
            sevenOut_q <= latchSeven_q[5:0];
            sevenOe_q <= ~dirSeven_q[5:0];
            sevenPullup_q <= pullupSeven_q[5:0] & dirSeven_q[5:0];
            eightOut_q <= latchEight_q[3:0];
            // digital drive on pins 0 to 2 blocked while opamp on; pin 3 still driven
            eightOe_q <= ~dirEight_q[3:0] & ~eightAnalogNow
                & ~({1'b0, {3{opamp_two_enable}}});
            eightAnalog_q <= eightAnalogNow;
            for (int i = 0; i < 4; i++) begin
                eightConvert_q[i] <= eightAnalogNow[i] && dirEight_q[i]
                    && (converter_channel_select == 4'(8 + i))
                    && (!opamp_two_enable || i == gpio_ports_pkg::OPAMP_OUT_BIT || i == 3);
            end
            opampOutOnPin_q <= eightAnalogNow[gpio_ports_pkg::OPAMP_OUT_BIT]
                && dirEight_q[gpio_ports_pkg::OPAMP_OUT_BIT] && opamp_two_enable;
            twelveOut_q <= latchTwelve_q[4:0];
            twelveOe_q <= ~dirTwelve_q[4:0] & ~oscOwned;
            intrLvdPullup_q <= pullupTwelve_q[gpio_ports_pkg::TWELVE_PULLUP_BIT]
                && dirTwelve_q[gpio_ports_pkg::TWELVE_PULLUP_BIT];
            twelveOscOwned_q <= oscOwned;
        end
    end

    // Key return sees the filtered pin level whatever the direction.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            key_return_input_q <= 6'h00;
        end else begin
            key_return_input_q <= pinLevel_q[7:2];
        end
    end

    // read pin or latch by direction
    always_comb begin
        rdata = 8'h00;
        hit = 1'b1;
        case (busReq.addr)
            // latch read back in output mode, pin level in input mode; analog port-eight pins in input mode and oscillator-owned pins read zero
            gpio_ports_pkg::ADDR_DATA_SIX: rdata = {6'h00, (dirSix_q[1:0] & pinLevel_q[1:0])
                | (~dirSix_q[1:0] & latchSix_q[1:0])};
            gpio_ports_pkg::ADDR_DATA_SEVEN: rdata = {2'h0, (dirSeven_q[5:0] & pinLevel_q[7:2])
                | (~dirSeven_q[5:0] & latchSeven_q[5:0])};
            gpio_ports_pkg::ADDR_DATA_EIGHT: rdata = {4'h0,
                (dirEight_q[3:0] & ~eightAnalogNow & pinLevel_q[11:8])
                | (~dirEight_q[3:0] & latchEight_q[3:0])};
            gpio_ports_pkg::ADDR_DATA_TWELVE: rdata = {3'h0,
                ((dirTwelve_q[4:0] & pinLevel_q[16:12])
                | (~dirTwelve_q[4:0] & latchTwelve_q[4:0])) & ~oscOwned};
            gpio_ports_pkg::ADDR_DIR_ONE: rdata = dirPortOne_q;
            gpio_ports_pkg::ADDR_DIR_TWO: rdata = dirPortTwo_q;
            gpio_ports_pkg::ADDR_DIR_THREE: rdata = dirPortThree_q;
            gpio_ports_pkg::ADDR_DIR_SIX: rdata = dirSix_q;
            gpio_ports_pkg::ADDR_DIR_SEVEN: rdata = dirSeven_q;
            gpio_ports_pkg::ADDR_DIR_EIGHT: rdata = dirEight_q;
            gpio_ports_pkg::ADDR_DIR_TWELVE: rdata = dirTwelve_q;
            gpio_ports_pkg::ADDR_ANALOG_CFG: rdata = {3'h0, analogCfg_q};
            gpio_ports_pkg::ADDR_PULLUP_SEVEN: rdata = {2'h0, pullupSeven_q[5:0]};
            gpio_ports_pkg::ADDR_PULLUP_TWELVE: rdata = {7'h00, pullupTwelve_q[0]};
            default: hit = 1'b0;
        endcase
    end

    // Registered read answer; unmapped addresses read zero with hit low.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            busRsp_q <= '0;
        end else if (busReq.read) begin
            busRsp_q.rdata <= rdata;
            busRsp_q.hit <= hit;
        end else begin
            busRsp_q <= '0;
        end
    end

endmodule : gpio_ports_six_to_twelve

`default_nettype wire

// ===== gpio_ports_six_to_twelve_tb.sv
/* Self-checking bench for the port 6/7/8/12 block.
   Assumes the checker binds itself and pin_world models the boards. */
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_six_to_twelve_tb;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    gpio_ports_pkg::bus_req_type busReq = '0;
    gpio_ports_pkg::bus_rsp_type busRsp_q;
    logic opampOn = 1'b0;
    logic [3:0] chanSel = 4'h0;
    gpio_ports_pkg::osc_mode_type oscMode = '0;
    logic [1:0] sixPin, sixOut, sixOe;
    logic [1:0] sixExtEn = 2'h0;
    logic [1:0] sixExtVal = 2'h0;
    logic [5:0] sevenExtEn = 6'h00;
    logic [5:0] sevenExtVal = 6'h00;
    logic [3:0] eightExtEn = 4'h0;
    logic [3:0] eightExtVal = 4'h0;
    logic [5:0] sevenPin, sevenOut, sevenOe, sevenPull, keyRet;
    logic [3:0] eightPin, eightOut, eightOe, eightAna, eightConv;
    logic [4:0] twelvePin, twelveOut, twelveOe, oscOwned;
    logic opampPin, intrPull;
    logic [7:0] dirOne, dirTwo, dirThree;
    int errorCnt = 0;
    int totalChecks = 0;
    int cycles = 0;
    logic [15:0] dirAddr [6] = '{gpio_ports_pkg::ADDR_DIR_ONE, gpio_ports_pkg::ADDR_DIR_TWO,
        gpio_ports_pkg::ADDR_DIR_THREE, gpio_ports_pkg::ADDR_DIR_SIX,
        gpio_ports_pkg::ADDR_DIR_EIGHT, gpio_ports_pkg::ADDR_DIR_TWELVE};
    logic [2:0] oscSet [3] = '{3'h4, 3'h2, 3'h1};
    logic [7:0] oscExp [3] = '{8'h06, 8'h02, 8'h18};

    always #4 sys_clk = ~sys_clk;

    gpio_ports_six_to_twelve dut (
        .sys_clk(sys_clk), .srst(srst), .busReq(busReq), .busRsp_q(busRsp_q),
        .opamp_two_enable(opampOn), .converter_channel_select(chanSel),
        .oscillator_mode_select(oscMode), .sixIn(sixPin), .sixOut_q(sixOut), .sixOe_q(sixOe),
        .sevenIn(sevenPin), .sevenOut_q(sevenOut), .sevenOe_q(sevenOe),
        .sevenPullup_q(sevenPull), .key_return_input_q(keyRet), .eightIn(eightPin),
        .eightOut_q(eightOut), .eightOe_q(eightOe), .eightAnalog_q(eightAna),
        .eightConvert_q(eightConv), .opampOutOnPin_q(opampPin), .twelveIn(twelvePin),
        .twelveOut_q(twelveOut), .twelveOe_q(twelveOe), .intrLvdPullup_q(intrPull),
        .twelveOscOwned_q(oscOwned), .dirPortOne_q(dirOne), .dirPortTwo_q(dirTwo),
        .dirPortThree_q(dirThree)
    );
    pin_world #(.W(2)) sixSide (.sys_clk(sys_clk), .oe(sixOe), .out(sixOut), .pull(2'h3),
        .extEn(sixExtEn), .extVal(sixExtVal), .level(sixPin));
    pin_world #(.W(6)) sevenSide (.sys_clk(sys_clk), .oe(sevenOe), .out(sevenOut),
        .pull(sevenPull), .extEn(sevenExtEn), .extVal(sevenExtVal), .level(sevenPin));
    pin_world #(.W(4)) eightSide (.sys_clk(sys_clk), .oe(eightOe), .out(eightOut),
        .pull(4'h0), .extEn(eightExtEn), .extVal(eightExtVal), .level(eightPin));
    pin_world #(.W(5)) twelveSide (.sys_clk(sys_clk), .oe(twelveOe), .out(twelveOut),
        .pull({4'h0, intrPull}), .extEn(5'h00), .extVal(5'h00), .level(twelvePin));

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        totalChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic send(input gpio_ports_pkg::bus_req_type r);
        @(posedge sys_clk);
        busReq <= r;
        @(posedge sys_clk);
        busReq <= '0;
    endtask : send
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        send('{addr: a, wdata: d, byteWrite: 1'b1, default: '0});
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e,
        input logic h);
        send('{addr: a, read: 1'b1, default: '0});
        #1;
        check("read data", e, busRsp_q.rdata & m);
        check("read hit", {7'h00, h}, {7'h00, busRsp_q.hit});
    endtask : rd
    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : settle
    task automatic results;
        $display("checks %0d mismatches %0d", totalChecks, errorCnt);
        if (errorCnt == 0 && totalChecks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : results

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errorCnt++;
            results();
        end
    end

    initial begin
        repeat (3) @(posedge sys_clk);
        srst <= 1'b0;
        settle(1);
        check("enables", 8'h00, {sixOe, sevenOe});
        check("enables high", 8'h00, {eightOe, 4'h0} | {3'h0, twelveOe});
        check("eight analog", 8'h00, {4'h0, eightAna});
        check("port three dir", 8'hFF, dirThree);
        rd(gpio_ports_pkg::ADDR_ANALOG_CFG, 8'hFF, 8'h10, 1'b1);
        rd(gpio_ports_pkg::ADDR_DIR_SEVEN, 8'hFF, 8'hFF, 1'b1);
        rd(16'h1234, 8'hFF, 8'h00, 1'b0);
        foreach (dirAddr[i]) begin
            rd(dirAddr[i], 8'hFF, 8'hFF, 1'b1);
            wr(dirAddr[i], 8'hFD);
            rd(dirAddr[i], 8'hFF, 8'hFD, 1'b1);
            send('{addr: dirAddr[i], bitWrite: 1'b1, bitSel: 3'h1, bitValue: 1'b1,
                default: '0});
            rd(dirAddr[i], 8'hFF, 8'hFF, 1'b1);
        end
        wr(gpio_ports_pkg::ADDR_DATA_SIX, 8'h01);
        wr(gpio_ports_pkg::ADDR_DIR_SIX, 8'hFC);
        sixExtEn <= 2'h1;
        settle(1);
        check("six pull low", 8'h02, {6'h00, sixOe});
        rd(gpio_ports_pkg::ADDR_DATA_SIX, 8'h03, 8'h01, 1'b1);
        wr(gpio_ports_pkg::ADDR_DIR_SIX, 8'hFF);
        settle(6);
        rd(gpio_ports_pkg::ADDR_DATA_SIX, 8'h03, 8'h02, 1'b1);
        wr(gpio_ports_pkg::ADDR_DATA_SEVEN, 8'h05);
        wr(gpio_ports_pkg::ADDR_PULLUP_SEVEN, 8'h3F);
        wr(gpio_ports_pkg::ADDR_DIR_SEVEN, 8'hF0);
        sevenExtEn <= 6'h10;
        settle(6);
        check("seven pull-up", 8'h30, {2'h0, sevenPull});
        check("seven enable", 8'h0F, {2'h0, sevenOe});
        check("seven latch", 8'h05, {2'h0, sevenOut});
        check("key return", 8'h25, {2'h0, keyRet});
        rd(gpio_ports_pkg::ADDR_DATA_SEVEN, 8'h3F, 8'h25, 1'b1);
        wr(gpio_ports_pkg::ADDR_DATA_EIGHT, 8'h0F);
        wr(gpio_ports_pkg::ADDR_DIR_EIGHT, 8'hF0);
        settle(1);
        check("eight enable", 8'h0F, {4'h0, eightOe});
        check("eight latch", 8'h0F, {4'h0, eightOut});
        opampOn <= 1'b1;
        settle(3);
        check("eight with amplifier", 8'h08, {4'h0, eightOe});
        // analog pins kept in input direction
        wr(gpio_ports_pkg::ADDR_DIR_EIGHT, 8'hFF);
        wr(gpio_ports_pkg::ADDR_ANALOG_CFG, 8'h09);
        chanSel <= 4'h9;
        settle(3);
        check("eight analog", 8'h0E, {4'h0, eightAna});
        check("amplifier out", 8'h01, {7'h00, opampPin});
        check("eight convert", 8'h02, {4'h0, eightConv});
        wr(gpio_ports_pkg::ADDR_ANALOG_CFG, 8'h10);
        opampOn <= 1'b0;
        chanSel <= 4'h0;
        wr(gpio_ports_pkg::ADDR_PULLUP_TWELVE, 8'h01);
        settle(1);
        check("interrupt pull-up", 8'h01, {7'h00, intrPull});
        eightExtEn <= 4'hF;
        eightExtVal <= 4'hA;
        settle(6);
        rd(gpio_ports_pkg::ADDR_DATA_EIGHT, 8'h0F, 8'h0A, 1'b1);
        wr(gpio_ports_pkg::ADDR_DIR_TWELVE, 8'hE0);
        foreach (oscSet[i]) begin
            @(posedge sys_clk);
            oscMode <= oscSet[i];
            settle(3);
            check("oscillator pins", oscExp[i], {3'h0, oscOwned});
            check("oscillator drive", 8'h1F & ~oscExp[i], {3'h0, twelveOe});
        end
        results();
    end
endmodule : gpio_ports_six_to_twelve_tb
`default_nettype wire

// ===== pin_world.sv
/* Model of the circuitry on a group of port pins: resolves each level.
   Assumes an enable of the block means the block drives its latch value. */
`timescale 1ns/1ps
`default_nettype none
module pin_world #(
    parameter int W = 2
) (
    // Clock
    input wire logic sys_clk,
    // Block side
    input wire logic [W-1:0] oe,
    input wire logic [W-1:0] out,
    input wire logic [W-1:0] pull,
    // Outside drivers
    input wire logic [W-1:0] extEn,
    input wire logic [W-1:0] extVal,
    // Resolved level
    output logic [W-1:0] level
);
    logic [W-1:0] wander_q = '0;
    // A floating pin keeps changing, so no stale level can pass for a pin value.
    always @(posedge sys_clk) begin
        wander_q <= ~wander_q;
    end
    assign level = (oe & out) | (~oe & extEn & extVal) | (~oe & ~extEn & pull)
        | (~oe & ~extEn & ~pull & wander_q);
endmodule : pin_world
`default_nettype wire
